// File: rtl/csr_core_special.v
// Core special registers: stack floors, link, program counter, combined status
// Notes on behaviour
// - With security present, four floors: secure/nonsecure main and process, banked.
// - Without security, just one main and one process floor.
// - Floor registers keep the limit address in bits 31 to 3.
// - Link register resets to all ones and holds return information.
// - Program counter resets to the reset vector fetched from the vector table.
// - Flags, exception number and execution state are disjoint fields of one word.
// - Moves accept combined, exec+exception (read only), flags+exception, flags+exec views.
// - Writes through any status view leave the exception number unchanged.
// - Software reads execution state as zero; writes to it are ignored.
// - Flags at 31, 30, 29, 28, 27; bits 23:16 and 9 reserved.
// - Flags-only selector write updates negative, zero, carry, overflow, saturation.
// - Exception number bits 8:0 report current exception, 16 to 495 external.
// - Exception field width follows interrupt count: 6, 7, 8 or 9 bits.
// - Execution state: resume or block state 26:25,15:10; instruction-state bit 24.
// - Interrupted multi-transfer may record next register in bits 15:12 and resume.
// - While resume point is held, bits 26:25 and 11:10 are zero.
// - Transfers that cannot resume restart from the first register.
// - Conditional block covers up to four conditional instructions after its start.
// - Transfers inside a conditional block restart rather than resume.
// - Instruction-state bit changes only on register branch, PC load, return, vector.
// - Executing with instruction-state bit zero raises a fault.
// - Moving a stack pointer below its floor raises an exception.
// - At reset instruction-state bit comes from vector bit 0; other status bits clear.
`timescale 1ns/1ps
`default_nettype none
`include "csr_regs.vh"
module csr_core_special #(
	parameter SECURE = 1,
	parameter NUM_IRQ = 480
) (
	// Clock and reset
	input wire i_core_clk,
	input wire i_rst_n,
	// Software special-register moves
	input wire i_mov_wr,
	input wire i_mov_rd,
	input wire [2:0] i_mov_sel,
	input wire [31:0] i_mov_wdata,
	input wire i_cur_secure,
	input wire i_sp_is_process,
	output reg [31:0] o_mov_rdata,
	// Reset vector fetch
	input wire i_vec_valid,
	input wire [31:0] i_vec_pc,
	// Pipeline updates
	input wire i_flags_upd,
	input wire [4:0] i_flags_val,
	input wire i_lr_wr,
	input wire [31:0] i_lr_data,
	input wire i_pc_wr,
	input wire [31:0] i_pc_data,
	input wire i_exc_upd,
	input wire [8:0] i_exc_num,
	input wire i_istate_wr,
	input wire i_istate_val,
	input wire i_exec_upd,
	input wire [7:0] i_exec_val,
	input wire i_xfer_intr,
	input wire [3:0] i_xfer_next_reg,
	input wire i_xfer_resumable,
	input wire i_exec_attempt,
	input wire i_sp_upd,
	input wire [31:0] i_sp_new,
	// Status and faults
	output reg [31:0] o_lr,
	output reg [31:0] o_pc,
	output reg [31:0] o_status,
	output reg o_xfer_restart,
	output reg o_state_fault,
	output reg o_stack_fault
);
	localparam EXC_W = (NUM_IRQ <= 47) ? 6 : (NUM_IRQ <= 111) ? 7 : (NUM_IRQ <= 239) ? 8 : 9;
	localparam NBANK = SECURE ? 2 : 1;

	// Packs the execution state byte into its split field positions
	function [31:0] exec_pack;
		input [7:0] s;
		input ist;
		begin
			exec_pack = {5'h00, s[7:6], ist, 8'h00, s[5:0], 10'h000};
		end
	endfunction

	reg [4:0] flags_q;
	reg [EXC_W-1:0] exc_q;
	reg istate_q;
	reg [7:0] exec_q;
	reg boot_q;
	reg [31:0] status_full;
	reg [31:0] view_d;
	wire in_block = (exec_q[7:6] != 2'h0) || (exec_q[1:0] != 2'h0);
	wire [31:0] floor_m [0:1];
	wire [31:0] floor_p [0:1];
	wire below_m [0:1];
	wire below_p [0:1];
	wire bank = (SECURE != 0) ? i_cur_secure : 1'b0;
	wire flags_sel = (i_mov_sel == `CSR_SEL_COMBINED) || (i_mov_sel == `CSR_SEL_FLAGS_EXC) ||
		(i_mov_sel == `CSR_SEL_FLAGS_EXEC) || (i_mov_sel == `CSR_SEL_FLAGS_ONLY);

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_bank
			if (g < NBANK) begin : g_on
				csr_floor_bank u_main (
					.i_core_clk(i_core_clk),
					.i_rst_n(i_rst_n),
					.i_wr_en(i_mov_wr && i_mov_sel == `CSR_SEL_MAIN_FLOOR && bank == g),
					.i_wr_data(i_mov_wdata),
					.i_sp_new(i_sp_new),
					.o_floor(floor_m[g]),
					.o_below(below_m[g])
				);
				csr_floor_bank u_proc (
					.i_core_clk(i_core_clk),
					.i_rst_n(i_rst_n),
					.i_wr_en(i_mov_wr && i_mov_sel == `CSR_SEL_PROC_FLOOR && bank == g),
					.i_wr_data(i_mov_wdata),
					.i_sp_new(i_sp_new),
					.o_floor(floor_p[g]),
					.o_below(below_p[g])
				);
			end else begin : g_off
				assign floor_m[g] = 32'h00000000;
				assign floor_p[g] = 32'h00000000;
				assign below_m[g] = 1'b0;
				assign below_p[g] = 1'b0;
			end
		end
	endgenerate

	// Reads: execution bits always masked out for software
	always @* begin
		status_full = 32'h00000000;
		status_full[31:27] = flags_q;
		status_full[EXC_W-1:0] = exc_q;
		case (i_mov_sel)
			`CSR_SEL_COMBINED: view_d = status_full & (`CSR_FLAGS_MASK | `CSR_EXC_MASK);
			`CSR_SEL_EXEC_EXC: view_d = status_full & `CSR_EXC_MASK;
			`CSR_SEL_FLAGS_EXC: view_d = status_full & (`CSR_FLAGS_MASK | `CSR_EXC_MASK);
			`CSR_SEL_FLAGS_EXEC: view_d = status_full & `CSR_FLAGS_MASK;
			`CSR_SEL_FLAGS_ONLY: view_d = status_full & `CSR_FLAGS_MASK;
			`CSR_SEL_MAIN_FLOOR: view_d = floor_m[bank];
			`CSR_SEL_PROC_FLOOR: view_d = floor_p[bank];
			default: view_d = 32'h00000000;
		endcase
	end

	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flags_q <= 5'h00;
			exc_q <= {EXC_W{1'b0}};
			istate_q <= 1'b0;
			exec_q <= 8'h00;
			boot_q <= 1'b1;
			o_lr <= `CSR_LINK_RESET;
			o_pc <= `CSR_PC_RESET;
			o_status <= 32'h00000000;
			o_mov_rdata <= 32'h00000000;
			o_xfer_restart <= 1'b0;
			o_state_fault <= 1'b0;
			o_stack_fault <= 1'b0;
		end else begin
			if (i_vec_valid) begin
				istate_q <= i_vec_pc[0];
				if (boot_q) begin
					o_pc <= {i_vec_pc[31:1], 1'b0};
				end
				boot_q <= 1'b0;
			end else if (i_istate_wr) begin
				istate_q <= i_istate_val;
			end
			if (i_pc_wr && !(i_vec_valid && boot_q)) begin
				o_pc <= i_pc_data;
			end
			if (i_lr_wr) begin
				o_lr <= i_lr_data;
			end
			// Software write of flags; exception and execution bits untouched
			if (i_mov_wr && flags_sel) begin
				flags_q <= i_mov_wdata[31:27];
			end else if (i_flags_upd) begin
				flags_q <= i_flags_val;
			end
			if (i_exc_upd) begin
				exc_q <= i_exc_num[EXC_W-1:0];
			end
			// Resume point only outside a conditional block; else restart
			if (i_xfer_intr) begin
				if (i_xfer_resumable && !in_block) begin
					exec_q <= {2'h0, i_xfer_next_reg, 2'h0};
					o_xfer_restart <= 1'b0;
				end else begin
					o_xfer_restart <= 1'b1;
				end
			end else begin
				o_xfer_restart <= 1'b0;
				if (i_exec_upd) begin
					exec_q <= i_exec_val;
				end
			end
			o_state_fault <= i_exec_attempt && !istate_q;
			o_stack_fault <= i_sp_upd && (i_sp_is_process ? below_p[bank] : below_m[bank]);
			o_status <= status_full | exec_pack(exec_q, istate_q);
			if (i_mov_rd) begin
				o_mov_rdata <= view_d;
			end
		end
	end
endmodule
`default_nettype wire

// File: rtl/csr_floor_bank.v
// One stack floor register with limit compare
`timescale 1ns/1ps
`default_nettype none
`include "csr_regs.vh"
module csr_floor_bank (
	// Clock and reset
	input wire i_core_clk,
	input wire i_rst_n,
	// Write port
	input wire i_wr_en,
	input wire [31:0] i_wr_data,
	// Limit check
	input wire [31:0] i_sp_new,
	output wire [31:0] o_floor,
	output wire o_below
);
	reg [31:0] floor_q;
	always @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			floor_q <= `CSR_FLOOR_RESET;
		end else if (i_wr_en) begin
			floor_q <= i_wr_data & `CSR_FLOOR_MASK;
		end
	end
	assign o_floor = floor_q;
	assign o_below = (i_sp_new < floor_q);
endmodule
`default_nettype wire

// File: rtl/csr_regs.vh
// Field positions, selectors and reset values of the core special registers
`ifndef CSR_REGS_VH
`define CSR_REGS_VH
// Special-register selectors for move to / move from
`define CSR_SEL_COMBINED 3'h0
`define CSR_SEL_EXEC_EXC 3'h1
`define CSR_SEL_FLAGS_EXC 3'h2
`define CSR_SEL_FLAGS_EXEC 3'h3
`define CSR_SEL_FLAGS_ONLY 3'h4
`define CSR_SEL_MAIN_FLOOR 3'h5
`define CSR_SEL_PROC_FLOOR 3'h6
// Combined status field positions
`define CSR_BIT_NEG 31
`define CSR_BIT_ZERO 30
`define CSR_BIT_CARRY 29
`define CSR_BIT_OVF 28
`define CSR_BIT_SAT 27
`define CSR_BIT_ISTATE 24
`define CSR_EXC_MSB 8
// Masks of the views
`define CSR_FLAGS_MASK 32'hf8000000
`define CSR_EXC_MASK 32'h000001ff
`define CSR_EXEC_MASK 32'h0700fc00
`define CSR_FLOOR_MASK 32'hfffffff8
// Reset values
`define CSR_LINK_RESET 32'hffffffff
`define CSR_FLOOR_RESET 32'h00000000
`define CSR_PC_RESET 32'h00000000
`endif

// File: tb/csr_core_props.sv
// Port-level assertions for the core special registers
`timescale 1ns/1ps
`default_nettype none
module csr_core_props (
	// Strobes and single-bit outputs
	input wire i_core_clk, i_rst_n, i_mov_wr, i_mov_rd, i_flags_upd, i_lr_wr, i_exc_upd,
	input wire i_exec_attempt, i_sp_upd, i_xfer_intr, o_state_fault, o_stack_fault, o_xfer_restart,
	// Buses
	input wire [2:0] i_mov_sel,
	input wire [4:0] i_flags_val,
	input wire [8:0] i_exc_num,
	input wire [31:0] i_mov_wdata, i_lr_data, o_lr, o_status, o_mov_rdata
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	a_lr_load: assert property (i_lr_wr |=> o_lr == $past(i_lr_data)) else $error("lr load");
	a_lr_hold: assert property (!i_lr_wr |=> $stable(o_lr)) else $error("lr moved");
	// Status output is built from the field registers, so it trails each update by one more cycle
	a_exc_load: assert property (i_exc_upd |=> ##1 o_status[8:0] == $past(i_exc_num, 2)) else $error("exc");
	a_exc_kept: assert property (!i_exc_upd |=> ##1 $stable(o_status[8:0])) else $error("exc moved");
	a_flags_sw: assert property (i_mov_wr && i_mov_sel == 3'h4 |=> ##1
		o_status[31:27] == $past(i_mov_wdata[31:27], 2)) else $error("flag write");
	a_flags_pipe: assert property (i_flags_upd && !i_mov_wr |=> ##1
		o_status[31:27] == $past(i_flags_val, 2)) else $error("flag update");
	a_exec_rdzero: assert property (i_mov_rd && i_mov_sel < 3'h5 |=>
		(o_mov_rdata & 32'h0700fc00) == 32'h0) else $error("exec read");
	a_resv_zero: assert property ((o_status & 32'h00ff0200) == 32'h0) else $error("reserved");
	a_fault_cause: assert property (o_state_fault |-> $past(i_exec_attempt)) else $error("fault");
	a_stack_cause: assert property (o_stack_fault |-> $past(i_sp_upd)) else $error("stack");
	a_restart_why: assert property (o_xfer_restart |-> $past(i_xfer_intr)) else $error("restart");
endmodule
bind csr_core_special csr_core_props u_props (.*);
`default_nettype wire

// File: tb/csr_core_special_test.sv
// Self-checking bench for the core special registers
`timescale 1ns/1ps
`default_nettype none
module csr_core_special_test;
	logic i_core_clk = 0, i_rst_n = 0, i_mov_wr = 0, i_mov_rd = 0, i_cur_secure = 0, i_sp_is_process = 0;
	logic i_vec_valid = 0, i_flags_upd = 0, i_lr_wr = 0, i_pc_wr = 0, i_exc_upd = 0, i_istate_wr = 0;
	logic i_istate_val = 0, i_exec_upd = 0, i_xfer_intr = 0, i_xfer_resumable = 0, i_exec_attempt = 0;
	logic i_sp_upd = 0, rd1 = 0;
	logic [2:0] i_mov_sel = 0;
	logic [3:0] i_xfer_next_reg = 0;
	logic [4:0] i_flags_val = 0;
	logic [7:0] i_exec_val = 0;
	logic [8:0] i_exc_num = 0;
	logic [31:0] i_mov_wdata = 0, i_vec_pc = 0, i_lr_data = 0, i_pc_data = 0, i_sp_new = 0, v;
	logic [31:0] q[$], f[4];
	wire [31:0] o_mov_rdata, o_lr, o_pc, o_status;
	wire o_xfer_restart, o_state_fault, o_stack_fault;
	int miscompares = 0, num_checks = 0, seed = 32'ha1ba;
	csr_core_special #(.SECURE(1), .NUM_IRQ(480)) DUT (.*);
	initial forever #2 i_core_clk = ~i_core_clk;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task test_done;
		if (miscompares == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask
	// Lowering the strobe then waiting keeps back-to-back calls from double assigning it
	task wr(input logic [2:0] s, input logic [31:0] d);
		i_mov_sel = s;
		i_mov_wdata = d;
		i_mov_wr = 1;
		cyc(1);
		i_mov_wr = 0;
		cyc(1);
	endtask
	task rd(input logic [2:0] s, input logic [31:0] e);
		i_mov_sel = s;
		i_mov_rd = 1;
		q.push_back(e);
		cyc(1);
		i_mov_rd = 0;
		cyc(1);
	endtask
	// Read data is registered, so it is sampled half a cycle after the taking edge
	always @(posedge i_core_clk) rd1 <= i_mov_rd;
	always @(negedge i_core_clk) if (rd1 === 1'b1 && q.size() > 0) chk(o_mov_rdata, q.pop_front());
	initial begin
		#100000;
		miscompares++;
		test_done;
	end
	initial begin
		cyc(5);
		chk(o_lr, 32'hffffffff);
		chk(o_pc, 32'h0);
		chk(o_status, 32'h0);
		i_rst_n = 1;
		i_vec_pc = 32'h00000101;
		i_vec_valid = 1;
		cyc(1);
		i_vec_valid = 0;
		cyc(1);
		chk(o_pc, 32'h00000100);
		chk(o_status, 32'h01000000);
		wr(3'h4, 32'hffffffff);
		rd(3'h0, 32'hf8000000);
		i_exc_num = 9'h1ef;
		i_exc_upd = 1;
		cyc(1);
		i_exc_upd = 0;
		v = $random(seed);
		wr(3'h0, v);
		rd(3'h2, v & 32'hf8000000 | 32'h1ef);
		wr(3'h1, ~v);
		rd(3'h3, v & 32'hf8000000);
		i_flags_val = 5'h15;
		i_flags_upd = 1;
		cyc(1);
		i_flags_upd = 0;
		rd(3'h0, 32'ha80001ef);
		v = $random(seed);
		i_lr_data = v;
		i_pc_data = ~v & 32'hfffffffe;
		i_lr_wr = 1;
		i_pc_wr = 1;
		cyc(1);
		i_lr_wr = 0;
		i_pc_wr = 0;
		chk(o_lr, v);
		chk(o_pc, ~v & 32'hfffffffe);
		for (int k = 0; k < 4; k++) begin
			f[k] = $random(seed) | 32'h100;
			i_cur_secure = k[1];
			wr(k[0] ? 3'h6 : 3'h5, f[k]);
		end
		for (int k = 0; k < 4; k++) begin
			i_cur_secure = k[1];
			rd(k[0] ? 3'h6 : 3'h5, f[k] & 32'hfffffff8);
		end
		i_cur_secure = 1;
		i_sp_new = (f[2] & 32'hfffffff8) - 32'h8;
		i_sp_upd = 1;
		cyc(1);
		chk(o_stack_fault, 1);
		i_sp_new = f[2] & 32'hfffffff8;
		cyc(1);
		chk(o_stack_fault, 0);
		i_sp_upd = 0;
		i_exec_attempt = 1;
		i_istate_wr = 1;
		cyc(1);
		chk(o_state_fault, 0);
		i_istate_wr = 0;
		cyc(1);
		chk(o_state_fault, 1);
		i_exec_attempt = 0;
		i_xfer_next_reg = 4'h5;
		i_xfer_resumable = 1;
		i_xfer_intr = 1;
		cyc(1);
		i_xfer_intr = 0;
		chk(o_xfer_restart, 0);
		cyc(1);
		chk(o_status & 32'h0600fc00, 32'h00005000);
		i_exec_val = 8'h01;
		i_exec_upd = 1;
		cyc(1);
		i_exec_upd = 0;
		i_xfer_intr = 1;
		cyc(1);
		i_xfer_intr = 0;
		chk(o_xfer_restart, 1);
		cyc(2);
		chk(q.size(), 0);
		test_done;
	end
endmodule
`default_nettype wire
